// ===== core/tcds_defines.svh
`ifndef TCDS_DEFINES_SVH
`define TCDS_DEFINES_SVH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define TCDS_A_CH0 4'h0
`define TCDS_A_ERRB 4'h4
`define TCDS_A_CTRL 4'h5
`define TCDS_A_HILIM 4'h6
`define TCDS_A_LOLIM 4'h7
`define TCDS_A_IRQST 4'h8
`define TCDS_A_IRQMSK 4'h9
`define TCDS_A_STAT 4'hA

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TCDS_B_RANGE 3
`define TCDS_B_SUPPLY 2
`define TCDS_C_VMODE 0
`define TCDS_C_OWSRC 1
`define TCDS_C_DOWN 2
`define TCDS_CTRL_RST 3'h2
`define TCDS_HI_RST 16'h3598
`define TCDS_LO_RST 16'hF574
`define TCDS_PIN_RST 2'h1

// ----------------------------------------
// Channel codes and scaling
// ----------------------------------------
`define TCDS_CODE_OVF 16'h7FFF
`define TCDS_CODE_UDF 16'h8000
`define TCDS_CODE_NOSUP 16'h7FFE
`define TCDS_CODE_DIAG 16'h0000
`define TCDS_V_OR_MAX 21'sh07EFF
`define TCDS_V_UR_MIN 21'sh1F8100
`define TCDS_V_SCALE 16'h587A
`define TCDS_V_SHIFT 16
`define TCDS_T_MUL 4'hA
`define TCDS_T_SHIFT 4
`define TCDS_OW_UV 20'h30D40

// ----------------------------------------
// Timing, milliseconds and clock in kHz
// ----------------------------------------
`define TCDS_UPD_MS 32'h195
`define TCDS_BLINK_MS 32'hFA
`define TCDS_CLK_KHZ 32'h186A0

`endif

// ===== core/tcds_pkg.sv
package tcds_pkg;
  typedef enum logic [1:0] {CH_OK, CH_OVER, CH_UNDER, CH_OPEN} tcds_chst_t;
  typedef enum logic [1:0] {MS_RUN, MS_NOSUP, MS_DIAG} tcds_mst_t;
endpackage

// ===== core/tcds_code_conv.sv
`timescale 1ns/1ns
`default_nettype none
`include "tcds_defines.svh"

module tcds_code_conv (
  input wire logic i_volt_mode,
  input wire logic i_ow_src_en,
  input wire logic i_down,
  input wire logic i_ow_det,
  input wire logic signed [19:0] i_uv,
  input wire logic signed [19:0] i_temp,
  input wire logic signed [15:0] i_hi_lim,
  input wire logic signed [15:0] i_lo_lim,
  output logic [15:0] o_code,
  output tcds_pkg::tcds_chst_t o_state
);
  import tcds_pkg::*;

  // ----------------------------------------
  // Magnitudes
  // ----------------------------------------
  // Scaling on the magnitude keeps negative codes mirror images
  wire uv_neg = i_uv[19];
  wire t_neg = i_temp[19];
  wire [19:0] uv_mag = uv_neg ? 20'(-i_uv) : i_uv;
  wire [19:0] t_mag = t_neg ? 20'(-i_temp) : i_temp;
  // R03 voltage full scale
  wire [35:0] v_prod = 36'(uv_mag) * 36'(`TCDS_V_SCALE);
  wire [19:0] v_mag = 20'(v_prod >> `TCDS_V_SHIFT);
  // R02 tenth degree units
  wire [23:0] t_prod = 24'(t_mag) * 24'(`TCDS_T_MUL);
  wire [19:0] t_div = 20'(t_prod >> `TCDS_T_SHIFT);
  wire [19:0] mag = i_volt_mode ? v_mag : t_div;
  wire neg = i_volt_mode ? uv_neg : t_neg;
  // R01 two's complement value
  wire signed [20:0] val = neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});

  // ----------------------------------------
  // Band limits
  // ----------------------------------------
  wire signed [20:0] hi_ext = {{5{i_hi_lim[15]}}, i_hi_lim};
  wire signed [20:0] lo_ext = {{5{i_lo_lim[15]}}, i_lo_lim};
  // R06 overrange band top
  wire signed [20:0] hi = i_volt_mode ? `TCDS_V_OR_MAX : hi_ext;
  // R07 underrange band bottom
  wire signed [20:0] lo = i_volt_mode ? `TCDS_V_UR_MIN : lo_ext;
  // R14 large input open
  wire big_in = uv_mag > `TCDS_OW_UV;
  wire open_w = big_in | (i_ow_det & i_ow_src_en);
  wire over = val > hi;
  wire under = val < lo;

  // ----------------------------------------
  // Code selection
  // ----------------------------------------
  // R08 open wire code
  wire [15:0] ow_code = i_down ? `TCDS_CODE_UDF : `TCDS_CODE_OVF;
  // R04 overflow saturation
  // R05 underflow saturation
  assign o_code = open_w ? ow_code :
                  over ? `TCDS_CODE_OVF :
                  under ? `TCDS_CODE_UDF : val[15:0];
  assign o_state = open_w ? CH_OPEN : over ? CH_OVER : under ? CH_UNDER : CH_OK;
endmodule // tcds_code_conv
`default_nettype wire

// ===== core/tcds_top.sv
// What this block does
// R01 - Every channel word to the host is a 16-bit two's complement value.
// R02 - Temperature codes count tenths of a degree.
// R03 - Voltage 80 mV full scale maps to 27648, negatives mirrored.
// R04 - Inputs above the overrange band report 32767.
// R05 - Inputs below the underrange band report -32768.
// R06 - Voltage codes 27649 to 32511 form the overrange band.
// R07 - Voltage codes -27649 to -32512 form the underrange band.
// R08 - Open wire gives -32768 or 32767, fault blinking, supply lamp on.
// R09 - Error byte bit 3 flags open wire or out of range only.
// R10 - Missing supply: bit 2 set, code 32766, lamps off, range bit clear.
// R11 - Diagnostic fault: configuration error, data 0000, fault on, supply lamp off.
// R12 - All channels refresh every 405 ms, only after a host read; the first update after reset copies without one.
// R13 - Without a host read, old values stay until the next update.
// R14 - Beyond about 200 mV, open wire is flagged even without current source.
// R15 - Host should read data at least once per update period.
// R16 - Host should switch off its own analog filtering.
// R17 - Fault free: conversion data, fault lamp off, supply lamp on, bits clear.
`timescale 1ns/1ns
`default_nettype none
`include "tcds_defines.svh"

module tcds_top #(
  parameter int UPD_CYC = `TCDS_UPD_MS * `TCDS_CLK_KHZ,
  parameter int BLINK_CYC = `TCDS_BLINK_MS * `TCDS_CLK_KHZ
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_smp_valid,
  input wire logic [1:0] i_smp_ch,
  input wire logic signed [19:0] i_smp_uv,
  input wire logic signed [19:0] i_smp_temp,
  input wire logic i_smp_ow,
  input wire logic i_user_pwr_ok,
  input wire logic i_diag_fail,
  output logic o_ow_src_en,
  output logic o_fault_led,
  output logic o_supply_led,
  output logic o_cfg_err,
  output logic [7:0] o_err_byte,
  output logic o_irq
);
  import tcds_pkg::*;

  function automatic logic is_ch(input logic [3:0] a);
    is_ch = a[3:2] == 2'(`TCDS_A_CH0 >> 2);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_m_r;
  logic [1:0] pin_s_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_m_r <= `TCDS_PIN_RST;
      pin_s_r <= `TCDS_PIN_RST;
    end else begin
      pin_m_r <= {i_diag_fail, i_user_pwr_ok};
      pin_s_r <= pin_m_r;
    end
  end
  wire pwr_ok = pin_s_r[0];
  wire diag = pin_s_r[1];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [2:0] ctrl_r;
  logic [15:0] hi_r;
  logic [15:0] lo_r;
  logic [3:0] msk_r;
  // Address decode shared by the write strobes and the read mux
  wire at_errb = i_addr == `TCDS_A_ERRB;
  wire at_ctrl = i_addr == `TCDS_A_CTRL;
  wire at_hi = i_addr == `TCDS_A_HILIM;
  wire at_lo = i_addr == `TCDS_A_LOLIM;
  wire at_irqst = i_addr == `TCDS_A_IRQST;
  wire at_msk = i_addr == `TCDS_A_IRQMSK;
  wire at_stat = i_addr == `TCDS_A_STAT;
  wire wr_ctrl = i_wr & at_ctrl;
  wire wr_hi = i_wr & at_hi;
  wire wr_lo = i_wr & at_lo;
  wire wr_msk = i_wr & at_msk;
  wire wr_clr = i_wr & at_irqst;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_r <= `TCDS_CTRL_RST;
      hi_r <= `TCDS_HI_RST;
      lo_r <= `TCDS_LO_RST;
      msk_r <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= i_wdata[2:0];
      if (wr_hi) hi_r <= i_wdata;
      if (wr_lo) lo_r <= i_wdata;
      if (wr_msk) msk_r <= i_wdata[3:0];
    end
  end
  assign o_ow_src_en = ctrl_r[`TCDS_C_OWSRC];

  // ----------------------------------------
  // Module condition
  // ----------------------------------------
  tcds_mst_t mst_r;
  tcds_mst_t mst_nxt;
  // R11 diagnostic is sticky
  always_comb begin
    case (mst_r)
      MS_RUN: mst_nxt = diag ? MS_DIAG : (!pwr_ok ? MS_NOSUP : MS_RUN);
      MS_NOSUP: mst_nxt = diag ? MS_DIAG : (pwr_ok ? MS_RUN : MS_NOSUP);
      MS_DIAG: mst_nxt = MS_DIAG;
      default: mst_nxt = MS_RUN;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) mst_r <= MS_RUN;
    else mst_r <= mst_nxt;
  end

  // ----------------------------------------
  // Conversion of incoming samples
  // ----------------------------------------
  logic [15:0] cv_code;
  tcds_chst_t cv_st;
  tcds_code_conv u_conv (
    .i_volt_mode(ctrl_r[`TCDS_C_VMODE]),
    .i_ow_src_en(ctrl_r[`TCDS_C_OWSRC]),
    .i_down(ctrl_r[`TCDS_C_DOWN]),
    .i_ow_det(i_smp_ow),
    .i_uv(i_smp_uv),
    .i_temp(i_smp_temp),
    .i_hi_lim(hi_r),
    .i_lo_lim(lo_r),
    .o_code(cv_code),
    .o_state(cv_st)
  );

  // ----------------------------------------
  // Update timing and host read tracking
  // ----------------------------------------
  logic [31:0] upd_cnt_r;
  logic [31:0] blk_cnt_r;
  logic blink_r;
  logic rd_flag_r;
  wire upd_tick = upd_cnt_r == 32'(UPD_CYC - 1);
  wire blk_tick = blk_cnt_r == 32'(BLINK_CYC - 1);
  wire host_ch_rd = i_rd & is_ch(i_addr);
  // R12 refresh after read
  wire copy = upd_tick & rd_flag_r;
  // R13 hold until read
  wire rd_flag_nxt = host_ch_rd | (rd_flag_r & ~upd_tick);
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      upd_cnt_r <= 32'h0;
      blk_cnt_r <= 32'h0;
      blink_r <= 1'b0;
      rd_flag_r <= 1'b1;
    end else begin
      upd_cnt_r <= upd_tick ? 32'h0 : upd_cnt_r + 32'h1;
      blk_cnt_r <= blk_tick ? 32'h0 : blk_cnt_r + 32'h1;
      blink_r <= blink_r ^ blk_tick;
      rd_flag_r <= rd_flag_nxt;
    end
  end

  // ----------------------------------------
  // Channel staging and presented words
  // ----------------------------------------
  // Staging follows every sample; the host sees only the presented copy
  logic [15:0] stg_code_r [4];
  tcds_chst_t stg_st_r [4];
  logic [15:0] pres_r [4];
  logic [3:0] ch_bad;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      wire ld = i_smp_valid & (i_smp_ch == 2'(gi));
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          stg_code_r[gi] <= 16'h0000;
          stg_st_r[gi] <= CH_OK;
          pres_r[gi] <= 16'h0000;
        end else begin
          if (ld) begin
            stg_code_r[gi] <= cv_code;
            stg_st_r[gi] <= cv_st;
          end
          if (copy) pres_r[gi] <= stg_code_r[gi];
        end
      end
      assign ch_bad[gi] = stg_st_r[gi] != CH_OK;
    end
  endgenerate
  wire range_any = |ch_bad;

  // ----------------------------------------
  // Error byte and indicators
  // ----------------------------------------
  logic [7:0] err_r;
  logic fault_r;
  logic sup_r;
  // Registered so the configuration error moves in step with the lamps
  logic cfg_r;
  wire run = mst_r == MS_RUN;
  // R09 range status bit
  wire range_bit = range_any & run;
  // R10 supply bad bit
  wire sup_bit = (mst_r == MS_NOSUP) | !pwr_ok;
  wire [7:0] err_nxt = 8'(range_bit) << `TCDS_B_RANGE | 8'(sup_bit) << `TCDS_B_SUPPLY;
  // R08 blinking fault lamp
  // R11 fault lamp steady
  wire fault_nxt = (mst_r == MS_DIAG) | (range_bit & blink_r);
  // R17 supply lamp on
  wire sup_nxt = run;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      err_r <= 8'h00;
      fault_r <= 1'b0;
      sup_r <= 1'b0;
      cfg_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
      fault_r <= fault_nxt;
      sup_r <= sup_nxt;
      cfg_r <= mst_r == MS_DIAG;
    end
  end
  assign o_err_byte = err_r;
  assign o_fault_led = fault_r;
  assign o_supply_led = sup_r;
  assign o_cfg_err = cfg_r;

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [3:0] irq_st_r;
  logic range_d_r;
  logic pwr_d_r;
  wire [3:0] irq_ev = {(mst_nxt == MS_DIAG) & (mst_r != MS_DIAG),
                       pwr_d_r & !pwr_ok, range_any & !range_d_r, copy};
  wire [3:0] irq_clr = wr_clr ? i_wdata[3:0] : 4'h0;
  // Set wins over a clear in the same cycle
  wire [3:0] irq_st_nxt = irq_ev | (irq_st_r & ~irq_clr);
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      irq_st_r <= 4'h0;
      range_d_r <= 1'b0;
      pwr_d_r <= 1'b1;
    end else begin
      irq_st_r <= irq_st_nxt;
      range_d_r <= range_any;
      pwr_d_r <= pwr_ok;
    end
  end
  assign o_irq = |(irq_st_r & msk_r);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // R10 missing supply code
  // R11 diagnostic zero data
  wire [15:0] ch_word = (mst_r == MS_DIAG) ? `TCDS_CODE_DIAG :
                        (mst_r == MS_NOSUP) ? `TCDS_CODE_NOSUP : pres_r[i_addr[1:0]];
  wire [15:0] stat_word = {10'h000, blink_r, rd_flag_r, range_any, mst_r, o_cfg_err};
  wire [15:0] rdata_nxt =
    !i_rd ? 16'h0000 :
    is_ch(i_addr) ? ch_word :
    at_errb ? {8'h00, err_r} :
    at_ctrl ? {13'h0000, ctrl_r} :
    at_hi ? hi_r :
    at_lo ? lo_r :
    at_irqst ? {12'h000, irq_st_r} :
    at_msk ? {12'h000, msk_r} :
    at_stat ? stat_word : 16'h0000;
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) o_rdata <= 16'h0000;
    else o_rdata <= rdata_nxt;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  err_read_a: assert property (i_rd && i_addr == `TCDS_A_ERRB // R09
    |=> o_rdata == {8'h00, $past(err_r)}) else $error("error byte read wrong");
  upd_hold_a: assert property (upd_tick && !rd_flag_r // R13
    |=> $stable(pres_r[0]) && $stable(pres_r[3])) else $error("data changed without read");
  upd_copy_a: assert property (copy // R12
    |=> pres_r[0] == $past(stg_code_r[0])) else $error("update did not copy");
  nosup_code_a: assert property (i_rd && is_ch(i_addr) && mst_r == MS_NOSUP // R10
    |=> o_rdata == `TCDS_CODE_NOSUP) else $error("no supply code wrong");
  nosup_bits_a: assert property (mst_r == MS_NOSUP // R10
    |=> err_r[`TCDS_B_SUPPLY] && !err_r[`TCDS_B_RANGE] && !o_supply_led && !o_fault_led)
    else $error("no supply status wrong");
  diag_led_a: assert property (mst_r == MS_DIAG // R11
    |=> (o_fault_led && !o_supply_led && o_cfg_err) [*2]) else $error("diagnostic lamps wrong");
  range_blink_a: assert property (range_any && run // R08
    |=> err_r[`TCDS_B_RANGE] && o_fault_led == $past(blink_r)) else $error("range report wrong");
  ovf_stage_a: assert property (i_smp_valid && i_smp_ch == 2'h0 && cv_st == CH_OVER // R04
    |=> stg_code_r[0] == `TCDS_CODE_OVF) else $error("overflow code wrong");
  ok_state_a: assert property (run && !range_any // R17
    |=> !o_fault_led && o_supply_led && !err_r[`TCDS_B_RANGE]) else $error("fault free state wrong");
  irq_set_a: assert property (irq_ev[0] && wr_clr && i_wdata[0] // R12
    |=> irq_st_r[0]) else $error("event lost against clear");

  // Channel 0 stands in for all four; the staging is one generate body
  wire [19:0] smp_mag = i_smp_uv[19] ? 20'(-i_smp_uv) : i_smp_uv;
  udf_stage_a: assert property (i_smp_valid && i_smp_ch == 2'h0 && cv_st == CH_UNDER // R05
    |=> stg_code_r[0] == `TCDS_CODE_UDF) else $error("underflow code wrong");
  open_code_a: assert property (i_smp_valid && i_smp_ch == 2'h0 && cv_st == CH_OPEN // R08
    |=> stg_code_r[0] == ($past(ctrl_r[`TCDS_C_DOWN]) ? `TCDS_CODE_UDF : `TCDS_CODE_OVF))
    else $error("open wire code wrong");
  ow_big_a: assert property (i_smp_valid && i_smp_ch == 2'h0 && smp_mag > `TCDS_OW_UV // R14
    |=> stg_st_r[0] == CH_OPEN) else $error("large input not open");
  v_band_a: assert property (i_smp_valid && i_smp_ch == 2'h0 && ctrl_r[`TCDS_C_VMODE] // R06
    && cv_st == CH_OK |=> $signed(stg_code_r[0]) <= `TCDS_V_OR_MAX
    && $signed(stg_code_r[0]) >= `TCDS_V_UR_MIN) else $error("voltage band exceeded");
  range_clear_a: assert property (!run // R09
    |=> !err_r[`TCDS_B_RANGE]) else $error("range bit outside run");
  diag_data_a: assert property (i_rd && is_ch(i_addr) && mst_r == MS_DIAG // R11
    |=> o_rdata == `TCDS_CODE_DIAG) else $error("diagnostic data wrong");
  copy_irq_a: assert property (copy // R12
    |=> irq_st_r[0]) else $error("update event missing");
  range_irq_a: assert property (range_any && !range_d_r // R09
    |=> irq_st_r[1]) else $error("range event missing");
  sup_irq_a: assert property (pwr_d_r && !pwr_ok // R10
    |=> irq_st_r[2] && err_r[`TCDS_B_SUPPLY]) else $error("supply event missing");
  diag_irq_a: assert property (mst_nxt == MS_DIAG && mst_r != MS_DIAG // R11
    |=> irq_st_r[3] && mst_r == MS_DIAG) else $error("diagnostic event missing");
  rd_flag_a: assert property (host_ch_rd // R13
    |=> rd_flag_r) else $error("host read not noted");

  copy_c: cover property (copy ##1 host_ch_rd);
  stale_c: cover property (upd_tick && !rd_flag_r);
  diag_c: cover property (mst_r == MS_NOSUP ##1 mst_r == MS_DIAG);
  range_c: cover property (range_any && run && blink_r);
  clash_c: cover property (irq_ev[0] && wr_clr && i_wdata[0]);
endmodule // tcds_top
`default_nettype wire

// ===== sim/tcds_host.sv
`timescale 1ns/1ns
`default_nettype none

module tcds_host (
  input wire logic i_sys_clk,
  input wire logic [15:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 4'hF;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // Idle address and data are scrambled so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    #1;
  endtask

  // raw word taken once per poll
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule // tcds_host

`default_nettype wire

// ===== sim/tb_thermocouple_data_status.sv
`timescale 1ns/1ns
`default_nettype none

module tb_thermocouple_data_status;
  localparam int UPD = 64;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_smp_valid = 1'b0;
  logic [1:0] i_smp_ch = 2'h0;
  logic signed [19:0] i_smp_uv = 20'h00000;
  logic signed [19:0] i_smp_temp = 20'h00000;
  logic i_smp_ow = 1'b0;
  logic i_user_pwr_ok = 1'b1;
  logic i_diag_fail = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic wr, rd, o_ow_src_en, o_fault_led, o_supply_led, o_cfg_err, o_irq;
  logic [7:0] o_err_byte;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  tcds_top #(.UPD_CYC(UPD), .BLINK_CYC(8)) i_dut (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_smp_valid(i_smp_valid),
    .i_smp_ch(i_smp_ch), .i_smp_uv(i_smp_uv), .i_smp_temp(i_smp_temp),
    .i_smp_ow(i_smp_ow), .i_user_pwr_ok(i_user_pwr_ok), .i_diag_fail(i_diag_fail),
    .o_ow_src_en(o_ow_src_en), .o_fault_led(o_fault_led), .o_supply_led(o_supply_led),
    .o_cfg_err(o_cfg_err), .o_err_byte(o_err_byte), .o_irq(o_irq)
  );

  tcds_host i_host (
    .i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr(wr), .o_rd(rd)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic summarize();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Ceiling is about twice the expected run
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic smp(input logic [1:0] ch, input logic signed [19:0] uv,
                     input logic signed [19:0] t, input logic ow);
    @(posedge i_sys_clk);
    i_smp_valid <= 1'b1;
    i_smp_ch <= ch;
    i_smp_uv <= uv;
    i_smp_temp <= t;
    i_smp_ow <= ow;
    @(posedge i_sys_clk);
    i_smp_valid <= 1'b0;
  endtask

  // Stage a sample, read once to arm the copy, then wait past two update ticks
  task automatic conv(input logic [1:0] ch, input logic signed [19:0] uv,
                      input logic signed [19:0] t, input logic ow, input logic [15:0] exp);
    logic [15:0] d;
    smp(ch, uv, t, ow);
    i_host.rd({2'h0, ch}, d);
    repeat (2 * UPD + 4) @(posedge i_sys_clk);
    rdchk({2'h0, ch}, exp);
  endtask

  // Counts fault lamp on-cycles over a 40-cycle window
  task automatic lamp(output int on);
    on = 0;
    repeat (40) begin
      @(posedge i_sys_clk);
      on += int'(o_fault_led);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(4'h5, 16'h0002);
    rdchk(4'h6, 16'h3598);
    rdchk(4'h7, 16'hF574);
    rdchk(4'h9, 16'h0000);
    rdchk(4'hB, 16'h0000);
    i_host.wr(4'h4, 16'hFFFF);
    rdchk(4'h4, 16'h0000);
    chk({14'h0, o_fault_led, o_supply_led}, 16'h0001);
    chk({15'h0, o_ow_src_en}, 16'h0001);
  endtask

  task automatic t_volt();
    int on;
    i_host.wr(4'h5, 16'h0003);
    conv(2'h0, 20'sd80000, 20'sd0, 1'b0, 16'h6C00);
    conv(2'h0, -20'sd60000, 20'sd0, 1'b0, 16'hAF00);
    conv(2'h0, 20'sd94000, 20'sd0, 1'b0, 16'h7EE7);
    conv(2'h0, -20'sd94000, 20'sd0, 1'b0, 16'h8119);
    conv(2'h0, -20'sd95000, 20'sd0, 1'b0, 16'h8000);
    conv(2'h0, 20'sd95000, 20'sd0, 1'b0, 16'h7FFF);
    chk({8'h0, o_err_byte}, 16'h0008);
    lamp(on);
    chk({15'h0, on > 0 && on < 40}, 16'h0001);
    i_host.wr(4'h5, 16'h0001);
    chk({15'h0, o_ow_src_en}, 16'h0000);
    conv(2'h0, 20'sd250000, 20'sd0, 1'b0, 16'h7FFF);
    conv(2'h0, 20'sd1000, 20'sd0, 1'b1, 16'h0159);
    i_host.wr(4'h5, 16'h0005);
    conv(2'h0, 20'sd250000, 20'sd0, 1'b0, 16'h8000);
    i_host.wr(4'h5, 16'h0007);
    conv(2'h0, 20'sd1000, 20'sd0, 1'b1, 16'h8000);
    lamp(on);
    chk({15'h0, on > 0 && on < 40}, 16'h0001);
    chk({15'h0, o_supply_led}, 16'h0001);
    conv(2'h0, 20'sd1000, 20'sd0, 1'b0, 16'h0159);
    chk({8'h0, o_err_byte}, 16'h0000);
  endtask

  task automatic t_temp();
    i_host.wr(4'h5, 16'h0002);
    conv(2'h1, 20'sd0, 20'sd1600, 1'b0, 16'h03E8);
    conv(2'h1, 20'sd0, -20'sd32, 1'b0, 16'hFFEC);
    conv(2'h1, 20'sd0, 20'sd22000, 1'b0, 16'h7FFF);
    conv(2'h1, 20'sd0, -20'sd4400, 1'b0, 16'h8000);
    conv(2'h1, 20'sd0, 20'sd1600, 1'b0, 16'h03E8);
  endtask

  // A refresh needs a host read between ticks; the copy also raises the update event
  task automatic t_hold();
    logic [15:0] d;
    conv(2'h3, 20'sd0, 20'sd160, 1'b0, 16'h0064);
    repeat (UPD + 4) @(posedge i_sys_clk);
    i_host.wr(4'h9, 16'h0001);
    chk({15'h0, o_irq}, 16'h0001);
    i_host.wr(4'h9, 16'h0000);
    chk({15'h0, o_irq}, 16'h0000);
    i_host.wr(4'h9, 16'h0001);
    i_host.wr(4'h8, 16'h0001);
    chk({15'h0, o_irq}, 16'h0000);
    smp(2'h3, 20'sd0, 20'sd320, 1'b0);
    repeat (2 * UPD + 4) @(posedge i_sys_clk);
    chk({15'h0, o_irq}, 16'h0000);
    rdchk(4'h3, 16'h0064);
    repeat (2 * UPD + 4) @(posedge i_sys_clk);
    rdchk(4'h3, 16'h00C8);
    chk({15'h0, o_irq}, 16'h0001);
    repeat (UPD + 4) @(posedge i_sys_clk);
    i_host.wr(4'h8, 16'h0001);
    chk({15'h0, o_irq}, 16'h0000);
    i_host.rd(4'h3, d);
    @(posedge o_irq);
    // Clear lands on the next copy tick, so the event must survive it
    i_host.rd(4'h3, d);
    repeat (UPD - 4) @(posedge i_sys_clk);
    i_host.wr(4'h8, 16'h0001);
    chk({15'h0, o_irq}, 16'h0001);
  endtask

  task automatic t_faults();
    int on;
    logic [15:0] d;
    @(posedge i_sys_clk);
    i_user_pwr_ok <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk({8'h0, o_err_byte}, 16'h0004);
    chk({14'h0, o_fault_led, o_supply_led}, 16'h0000);
    rdchk(4'h0, 16'h7FFE);
    @(posedge i_sys_clk);
    i_user_pwr_ok <= 1'b1;
    i_diag_fail <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk({15'h0, o_cfg_err}, 16'h0001);
    lamp(on);
    chk(16'(on), 16'h0028);
    chk({15'h0, o_supply_led}, 16'h0000);
    chk({15'h0, o_err_byte[3]}, 16'h0000);
    rdchk(4'h0, 16'h0000);
    rdchk(4'h8, 16'h000F);
    i_host.rd(4'hA, d);
    chk(d & 16'hFFCF, 16'h0005);
  endtask

  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    t_reset();
    t_volt();
    t_temp();
    t_hold();
    t_faults();
    summarize();
  end
endmodule // tb_thermocouple_data_status

`default_nettype wire
